// [core/cqr_consts.svh]
// constants for the configuration query responder
// Notes on behaviour
// [R1] queries report committed settings, never staged edits
// [R2] unavailable analyzer instance selected raises an error
// [R3] adjustment query returns one integer 0 to 4
// [R4] codes 1/4 current corrected, 2/3 voltage corrected
// [R5] range code: 0 hi,1 lo,2 auto-hi,3 auto-lo
// [R6] scaling query returns scale then offset, both real
// [R7] unscaled channel reports 0.0 for both fields
// [R8] bandwidth code: 0 auto, 1 none, 2 fixed
// [R9] fixed bandwidth appends real frequency in hertz
// [R10] host gives channel or instance selector per query
// [R11] unknown keyword or malformed selector: error, no data
`ifndef CQR_CONSTS_SVH
`define CQR_CONSTS_SVH
`define CQR_NUM_INST      3
`define CQR_NUM_CHAN      4
`define CQR_WORD_W        32
`define CQR_SEL_MIN       4'h1
`define CQR_SEL_INST_MAX  4'h3
`define CQR_SEL_CHAN_MAX  4'h4
`define CQR_EDIT_INST_MAX 2'h2
`define CQR_ADJ_NONE      3'h0
`define CQR_ADJ_MAX       3'h4
`define CQR_RANGE_HI      2'h0
`define CQR_RANGE_LO      2'h1
`define CQR_RANGE_AUTO_HI 2'h2
`define CQR_RANGE_AUTO_LO 2'h3
`define CQR_BW_AUTO       2'h0
`define CQR_BW_NONE       2'h1
`define CQR_BW_FIXED      2'h2
`define CQR_REAL_ZERO     32'h00000000
`endif

// [core/cqr_pkg.sv]
// types of the configuration query responder
package cqr_pkg;
`include "cqr_consts.svh"

	typedef enum logic [2:0] {
		CQR_KW_ADJUSTMENT_QUERY = 3'b000,
		CQR_KW_RANGE  = 3'b001,
		CQR_KW_SCALE  = 3'b010,
		CQR_KW_BW     = 3'b011
	} cqr_kw_t;

	typedef enum logic [2:0] {
		CQR_IT_ADJUSTMENT_QUERY   = 3'b000,
		CQR_IT_RANGE    = 3'b001,
		CQR_IT_SCALE_EN = 3'b010,
		CQR_IT_SCALE    = 3'b011,
		CQR_IT_OFFSET   = 3'b100,
		CQR_IT_BW_MODE  = 3'b101,
		CQR_IT_BW_FREQ  = 3'b110
	} cqr_item_t;

	typedef enum logic [1:0] {
		CQR_ERR_NONE    = 2'b00,
		CQR_ERR_KEYWORD = 2'b01,
		CQR_ERR_SEL     = 2'b10,
		CQR_ERR_UNAVAIL = 2'b11
	} cqr_err_t;

	typedef enum logic [1:0] {
		CQR_SER_IDLE = 2'b00,
		CQR_SER_ONE  = 2'b01,
		CQR_SER_TWO  = 2'b10
	} cqr_ser_st_t;

	typedef struct packed {
		logic [`CQR_NUM_INST-1:0][2:0]              adjustment_query;
		logic [`CQR_NUM_CHAN-1:0]                   range_auto;
		logic [`CQR_NUM_CHAN-1:0]                   range_lo;
		logic [`CQR_NUM_CHAN-1:0]                   scale_en;
		logic [`CQR_NUM_CHAN-1:0][`CQR_WORD_W-1:0]  scale;
		logic [`CQR_NUM_CHAN-1:0][`CQR_WORD_W-1:0]  offset;
		logic [`CQR_NUM_INST-1:0][1:0]              bw_mode;
		logic [`CQR_NUM_INST-1:0][`CQR_WORD_W-1:0]  bw_freq;
	} cqr_cfg_t;

	typedef struct packed {
		cqr_cfg_t active;
		cqr_cfg_t staged;
		logic     err;
		cqr_err_t err_code;
	} cqr_state_t;

	typedef struct packed {
		cqr_ser_st_t                 st;
		logic [1:0]                  is_real;
		logic [1:0][`CQR_WORD_W-1:0] data;
	} cqr_ser_t;
endpackage : cqr_pkg

// [core/cqr_fmt_if.sv]
// carrier of reply fields from the responder to the field serialiser
`timescale 1ns/1ps
interface cqr_fmt_if;
	logic                   load;
	logic                   two;
	logic [1:0]             is_real;
	logic [1:0][31:0]       data;
	logic                   busy;

	modport src (
		output load,
		output two,
		output is_real,
		output data,
		input  busy
	);
	modport sink (
		input  load,
		input  two,
		input  is_real,
		input  data,
		output busy
	);
endinterface : cqr_fmt_if

// [core/cqr_field_ser.sv]
// serialiser that hands reply fields to the transport one at a time
`timescale 1ns/1ps
module cqr_field_ser
	import cqr_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	cqr_fmt_if.sink          fmt,
	output logic             field_valid,
	input  wire logic        field_ready,
	output logic             field_is_real,
	output logic             field_last,
	output logic [31:0]      field_data
);
	cqr_ser_t s_q;
	cqr_ser_t s_d;

	assign fmt.busy      = (s_q.st != CQR_SER_IDLE);
	assign field_valid   = (s_q.st != CQR_SER_IDLE);
	assign field_last    = (s_q.st == CQR_SER_ONE);
	assign field_is_real = s_q.is_real[0];
	assign field_data    = s_q.data[0];

	always_comb begin
		s_d = s_q;
		case (s_q.st)
			CQR_SER_IDLE: begin
				if (fmt.load) begin
					s_d.is_real = fmt.is_real;
					s_d.data    = fmt.data;
					s_d.st      = fmt.two ? CQR_SER_TWO : CQR_SER_ONE; // [R6]
				end
			end
			CQR_SER_TWO: begin
				if (field_ready) begin
					// second field moves to the output slot
					s_d.is_real[0] = s_q.is_real[1];
					s_d.data[0]    = s_q.data[1];
					s_d.st         = CQR_SER_ONE;
				end
			end
			CQR_SER_ONE: begin
				if (field_ready) begin
					s_d.st = CQR_SER_IDLE;
				end
			end
			default: begin
				s_d.st = CQR_SER_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : cqr_field_ser

// [core/cqr_responder.sv]
// measurement configuration query responder with staged and active settings
`timescale 1ns/1ps
module cqr_responder
	import cqr_pkg::*;
(
	input  wire logic                      ref_clk,
	input  wire logic                      rst_b,
	input  wire logic                      edit_valid,
	input  wire cqr_item_t                 edit_item,
	input  wire logic [1:0]                edit_index,
	input  wire logic [31:0]               edit_data,
	input  wire logic                      edit_commit,
	input  wire logic                      edit_discard,
	input  wire logic [`CQR_NUM_INST-1:0]  inst_avail,
	input  wire logic [`CQR_NUM_CHAN-1:0]  range_lo_live,
	input  wire logic                      query_valid,
	output logic                           query_ready,
	input  wire cqr_kw_t                   query_keyword,
	input  wire logic [3:0]                query_selector,
	input  wire logic                      query_selector_ok,
	output logic                           query_error,
	output cqr_err_t                       query_err_code,
	output logic                           field_valid,
	input  wire logic                      field_ready,
	output logic                           field_is_real,
	output logic                           field_last,
	output logic [31:0]                    field_data
);
	cqr_state_t s_q;
	cqr_state_t s_d;
	cqr_fmt_if  fmt ();

	logic                          inst_kw;
	logic                          chan_kw;
	logic                          sel_in_range;
	logic [1:0]                    idx;
	logic                          take;
	logic                          err_now;
	cqr_err_t                      err_kind;
	logic [`CQR_NUM_CHAN-1:0][1:0] range_code;
	logic                          ans_two;
	logic [1:0]                    ans_is_real;
	logic [1:0][31:0]              ans_data;

	assign take = query_valid && query_ready;

	assign query_ready    = !fmt.busy;
	assign query_error    = s_q.err;
	assign query_err_code = s_q.err_code;

	// selector kind follows the keyword
	always_comb begin
		inst_kw = (query_keyword == CQR_KW_ADJUSTMENT_QUERY) || (query_keyword == CQR_KW_BW); // [R10]
		chan_kw = (query_keyword == CQR_KW_RANGE) || (query_keyword == CQR_KW_SCALE); // [R10]
		idx     = query_selector[1:0] - 2'h1;
		if (inst_kw) begin
			sel_in_range = (query_selector >= `CQR_SEL_MIN) &&
				(query_selector <= `CQR_SEL_INST_MAX);
		end else begin
			sel_in_range = (query_selector >= `CQR_SEL_MIN) &&
				(query_selector <= `CQR_SEL_CHAN_MAX);
		end
	end

	// refusal priority: keyword, then selector, then instance availability
	// idx is only trusted once the selector has passed its range check
	always_comb begin
		err_now  = 1'b0;
		err_kind = CQR_ERR_NONE;
		if (!inst_kw && !chan_kw) begin
			err_now  = 1'b1; // [R11]
			err_kind = CQR_ERR_KEYWORD;
		end else if (!query_selector_ok || !sel_in_range) begin
			err_now  = 1'b1; // [R11]
			err_kind = CQR_ERR_SEL;
		end else if (inst_kw && !inst_avail[idx]) begin
			err_now  = 1'b1; // [R2]
			err_kind = CQR_ERR_UNAVAIL;
		end
	end

	// auto-ranged channels report the range the ranger sits on at the taking edge
	always_comb begin
		for (int c = 0; c < `CQR_NUM_CHAN; c++) begin
			if (s_q.active.range_auto[c]) begin
				range_code[c] = range_lo_live[c] ? `CQR_RANGE_AUTO_LO : `CQR_RANGE_AUTO_HI; // [R5]
			end else begin
				range_code[c] = s_q.active.range_lo[c] ? `CQR_RANGE_LO : `CQR_RANGE_HI; // [R5]
			end
		end
	end

	// answers read the active copy, never the staged one
	always_comb begin
		ans_two     = 1'b0;
		ans_is_real = 2'b00;
		ans_data    = '0;
		case (query_keyword)
			CQR_KW_ADJUSTMENT_QUERY: begin
				// 1/4 correct current by voltage-input current, 2/3 the reverse
				ans_data[0] = {29'h0, s_q.active.adjustment_query[idx]}; // [R1] [R3] [R4]
			end
			CQR_KW_RANGE: begin
				ans_data[0] = {30'h0, range_code[idx]}; // [R1] [R5]
			end
			CQR_KW_SCALE: begin
				ans_two     = 1'b1; // [R6]
				ans_is_real = 2'b11;
				if (s_q.active.scale_en[idx]) begin
					ans_data[0] = s_q.active.scale[idx]; // [R6]
					ans_data[1] = s_q.active.offset[idx];
				end else begin
					ans_data[0] = `CQR_REAL_ZERO; // [R7]
					ans_data[1] = `CQR_REAL_ZERO; // [R7]
				end
			end
			default: begin
				ans_data[0] = {30'h0, s_q.active.bw_mode[idx]}; // [R8]
				if (s_q.active.bw_mode[idx] == `CQR_BW_FIXED) begin
					ans_two        = 1'b1; // [R9]
					ans_is_real[1] = 1'b1;
					ans_data[1]    = s_q.active.bw_freq[idx]; // [R9]
				end
			end
		endcase
	end

	always_comb begin
		s_d         = s_q;
		s_d.err     = 1'b0;
		fmt.load    = 1'b0;
		fmt.two     = 1'b0;
		fmt.is_real = 2'b00;
		fmt.data    = '0;

		// edits land in the staged copy only
		if (edit_valid) begin
			case (edit_item)
				CQR_IT_ADJUSTMENT_QUERY: begin
					if (edit_index <= `CQR_EDIT_INST_MAX && edit_data[2:0] <= `CQR_ADJ_MAX &&
						edit_data[31:3] == 29'h0) begin
						s_d.staged.adjustment_query[edit_index] = edit_data[2:0]; // [R3]
					end
				end
				CQR_IT_RANGE: begin
					s_d.staged.range_auto[edit_index] = edit_data[1];
					s_d.staged.range_lo[edit_index]   = edit_data[0];
				end
				CQR_IT_SCALE_EN: begin
					s_d.staged.scale_en[edit_index] = edit_data[0];
				end
				CQR_IT_SCALE: begin
					s_d.staged.scale[edit_index] = edit_data;
				end
				CQR_IT_OFFSET: begin
					s_d.staged.offset[edit_index] = edit_data;
				end
				CQR_IT_BW_MODE: begin
					if (edit_index <= `CQR_EDIT_INST_MAX && edit_data[1:0] <= `CQR_BW_FIXED &&
						edit_data[31:2] == 30'h0) begin
						s_d.staged.bw_mode[edit_index] = edit_data[1:0]; // [R8]
					end
				end
				CQR_IT_BW_FREQ: begin
					if (edit_index <= `CQR_EDIT_INST_MAX) begin
						s_d.staged.bw_freq[edit_index] = edit_data;
					end
				end
				default: begin
					s_d.staged = s_q.staged;
				end
			endcase
		end

		// commit takes an edit of the same cycle along with it
		if (edit_commit) begin
			s_d.active = s_d.staged; // [R1]
		end else if (edit_discard) begin
			s_d.staged = s_q.active;
		end

		// a refused query hands nothing to the serialiser
		if (take) begin
			s_d.err_code = err_kind;
			if (err_now) begin
				s_d.err = 1'b1; // [R2] [R11]
			end else begin
				fmt.load    = 1'b1;
				fmt.two     = ans_two;
				fmt.is_real = ans_is_real;
				fmt.data    = ans_data;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	cqr_field_ser u_ser (
		.ref_clk       (ref_clk),
		.rst_b         (rst_b),
		.fmt           (fmt.sink),
		.field_valid   (field_valid),
		.field_ready   (field_ready),
		.field_is_real (field_is_real),
		.field_last    (field_last),
		.field_data    (field_data)
	);
endmodule : cqr_responder

// [tb/cqr_props.sv]
// assertions on the query responder ports
`timescale 1ns/1ps
module cqr_props
	import cqr_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic [2:0]  inst_avail,
	input wire logic        query_valid,
	input wire logic        query_ready,
	input wire cqr_kw_t     query_keyword,
	input wire logic [3:0]  query_selector,
	input wire logic        query_selector_ok,
	input wire logic        query_error,
	input wire cqr_err_t    query_err_code,
	input wire logic        field_valid,
	input wire logic        field_ready,
	input wire logic        field_is_real,
	input wire logic        field_last,
	input wire logic [31:0] field_data
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	logic tk;
	logic sg;
	assign tk = query_valid & query_ready;
	assign sg = query_selector_ok & (query_selector != 4'h0);
	a_kw_unknown: assert property (tk && query_keyword > CQR_KW_BW
		|=> query_error && query_err_code == CQR_ERR_KEYWORD) else $error("keyword not refused");
	a_sel_bad: assert property (tk && query_keyword <= CQR_KW_BW && !query_selector_ok
		|=> query_error && query_err_code == CQR_ERR_SEL) else $error("selector not refused");
	a_inst_gone: assert property (tk && query_keyword == CQR_KW_ADJUSTMENT_QUERY && sg
		&& query_selector < 4'h4 && !inst_avail[query_selector[1:0] - 2'h1]
		|=> query_error && query_err_code == CQR_ERR_UNAVAIL) else $error("instance not refused");
	a_err_once: assert property (!tk |=> !query_error)
		else $error("error without a taken query");
	a_err_nodata: assert property (query_error |-> !field_valid)
		else $error("data with error");
	a_field_hold: assert property (field_valid && !field_ready
		|=> field_valid && $stable(field_data) && $stable(field_last)) else $error("field not held");
	a_int_max: assert property (field_valid && !field_is_real |-> field_data <= 32'h4)
		else $error("integer field out of range");
	a_range_one: assert property (tk && query_keyword == CQR_KW_RANGE && sg && query_selector < 4'h5
		|=> field_valid && field_last && !field_is_real && field_data < 32'h4) else $error("bad range");
	a_scale_two: assert property (tk && query_keyword == CQR_KW_SCALE && sg && query_selector < 4'h5
		|=> field_valid && field_is_real && !field_last) else $error("bad scale reply");
	c_bw: cover property (tk && query_keyword == CQR_KW_BW);
	c_real_last: cover property (field_valid && field_is_real && field_last);
	c_err: cover property (query_error);
endmodule : cqr_props
bind cqr_responder cqr_props u_cqr_props (.*);

// [tb/cqr_host_model.sv]
// field sink of the remote host, stalls when asked
`timescale 1ns/1ps
module cqr_host_model (
	input  wire logic stall,
	input  wire logic field_valid,
	output logic      field_ready
);
	assign field_ready = field_valid & ~stall;
endmodule : cqr_host_model

// [tb/tb_top.sv]
// self-checking bench for the configuration query responder
`timescale 1ns/1ps
module tb_top;
	import cqr_pkg::*;
	logic        ref_clk, rst_b, edit_valid, edit_commit, edit_discard, slow, stall;
	logic        query_valid, query_ready, query_selector_ok, query_error;
	logic        field_valid, field_ready, field_is_real, field_last, er, fl, rd;
	cqr_item_t   edit_item;
	cqr_kw_t     query_keyword;
	cqr_err_t    query_err_code, ec;
	logic [1:0]  edit_index;
	logic [2:0]  inst_avail;
	logic [3:0]  range_lo_live, query_selector;
	logic [31:0] edit_data, field_data;
	logic [31:0] fd [2];
	logic        fr [2];
	int          n, cyc, miscompares, checks;
	cqr_responder u_cqr_responder (.*);
	cqr_host_model u_cqr_host_model (.stall(stall), .field_valid(field_valid),
		.field_ready(field_ready));
	task automatic print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic ed(input cqr_item_t it, input logic [1:0] ix, input logic [31:0] d,
		input logic c);
		edit_valid = 1'b1;
		edit_item = it;
		edit_index = ix;
		edit_data = d;
		edit_commit = c;
		@(posedge ref_clk);
		#1 edit_valid = 1'b0;
		edit_commit = 1'b0;
		// let an edge pass so a following call never re-raises the strobe in this step
		@(posedge ref_clk);
		#1;
	endtask : ed
	task automatic q(input cqr_kw_t kw, input logic [3:0] s, input logic ok);
		n = 0;
		er = 1'b0;
		fl = 1'b0;
		query_valid = 1'b1;
		query_keyword = kw;
		query_selector = s;
		query_selector_ok = ok;
		@(posedge ref_clk);
		#1 query_valid = 1'b0;
		for (int i = 0; i < 20 && !fl && !er; i++) begin
			@(negedge ref_clk);
			if (i == 0) begin
				rd = query_ready;
			end
			er = query_error;
			ec = query_err_code;
			if (field_valid && field_ready && n < 2) begin
				fd[n] = field_data;
				fr[n] = field_is_real;
				fl = field_last;
				n++;
			end
		end
		@(posedge ref_clk);
		#1;
	endtask : q
	task automatic qi(input cqr_kw_t kw, input logic [3:0] s, input logic [31:0] e);
		q(kw, s, 1'b1);
		chk("count", 32'h1, n);
		chk("int", e, fd[0]);
		chk("is_real", 32'h0, {31'h0, fr[0]});
		chk("ready", 32'h0, {31'h0, rd});
	endtask : qi
	task automatic qe(input cqr_kw_t kw, input logic [3:0] s, input logic ok, input cqr_err_t c);
		q(kw, s, ok);
		chk("error", 32'h1, {31'h0, er});
		chk("code", {30'h0, c}, {30'h0, ec});
		chk("count", 32'h0, n);
		chk("ready", 32'h1, {31'h0, rd});
	endtask : qe
	task automatic s_staged;
		ed(CQR_IT_ADJUSTMENT_QUERY, 2'h0, 32'h2, 1'b0);
		qi(CQR_KW_ADJUSTMENT_QUERY, 4'h1, 32'h0);
		ed(CQR_IT_ADJUSTMENT_QUERY, 2'h0, 32'h2, 1'b1);
		qi(CQR_KW_ADJUSTMENT_QUERY, 4'h1, 32'h2);
		ed(CQR_IT_ADJUSTMENT_QUERY, 2'h0, 32'h4, 1'b0);
		edit_discard = 1'b1;
		@(posedge ref_clk);
		#1 edit_discard = 1'b0;
		ed(CQR_IT_RANGE, 2'h3, 32'h0, 1'b1);
		qi(CQR_KW_ADJUSTMENT_QUERY, 4'h1, 32'h2);
	endtask : s_staged
	task automatic s_codes;
		for (int c = 0; c < 5; c++) begin
			ed(CQR_IT_ADJUSTMENT_QUERY, 2'h1, c, 1'b1);
			qi(CQR_KW_ADJUSTMENT_QUERY, 4'h2, c);
		end
		ed(CQR_IT_ADJUSTMENT_QUERY, 2'h1, 32'h5, 1'b1);
		qi(CQR_KW_ADJUSTMENT_QUERY, 4'h2, 32'h4);
	endtask : s_codes
	task automatic s_range;
		for (int c = 0; c < 4; c++) begin
			range_lo_live = {1'b0, c == 3, 2'h0};
			ed(CQR_IT_RANGE, 2'h2, (c < 2) ? c : 2, 1'b1);
			qi(CQR_KW_RANGE, 4'h3, c);
		end
	endtask : s_range
	task automatic s_scale;
		ed(CQR_IT_SCALE, 2'h1, 32'h3F800000, 1'b0);
		ed(CQR_IT_OFFSET, 2'h1, 32'h40000000, 1'b1);
		q(CQR_KW_SCALE, 4'h2, 1'b1);
		chk("zero scale", 32'h0, fd[0]);
		chk("zero offset", 32'h0, fd[1]);
		ed(CQR_IT_SCALE_EN, 2'h1, 32'h1, 1'b1);
		slow = 1'b1;
		q(CQR_KW_SCALE, 4'h2, 1'b1);
		slow = 1'b0;
		chk("count", 32'h2, n);
		chk("scale", 32'h3F800000, fd[0]);
		chk("offset", 32'h40000000, fd[1]);
		chk("real", 32'h1, {31'h0, fr[0] & fr[1]});
	endtask : s_scale
	task automatic s_bw;
		ed(CQR_IT_BW_FREQ, 2'h1, 32'h447A0000, 1'b0);
		for (int c = 0; c < 3; c++) begin
			ed(CQR_IT_BW_MODE, 2'h1, c, 1'b1);
			q(CQR_KW_BW, 4'h2, 1'b1);
			chk("bw code", c, fd[0]);
			chk("bw count", (c == 2) ? 2 : 1, n);
		end
		chk("bw freq", 32'h447A0000, fd[1]);
		chk("freq real", 32'h1, {31'h0, fr[1]});
	endtask : s_bw
	task automatic s_reset;
		rst_b = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		qi(CQR_KW_ADJUSTMENT_QUERY, 4'h2, 32'h0);
		qi(CQR_KW_BW, 4'h2, 32'h0);
	endtask : s_reset
	task automatic s_err;
		qe(CQR_KW_ADJUSTMENT_QUERY, 4'h3, 1'b1, CQR_ERR_UNAVAIL);
		qe(CQR_KW_BW, 4'h3, 1'b1, CQR_ERR_UNAVAIL);
		qe(cqr_kw_t'(3'h5), 4'h1, 1'b1, CQR_ERR_KEYWORD);
		qe(CQR_KW_RANGE, 4'h1, 1'b0, CQR_ERR_SEL);
		qe(CQR_KW_SCALE, 4'h5, 1'b1, CQR_ERR_SEL);
		qe(CQR_KW_BW, 4'h4, 1'b1, CQR_ERR_SEL);
		qi(CQR_KW_RANGE, 4'h4, 32'h0);
	endtask : s_err
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		stall <= slow & ~stall;
		if (cyc > 3000) begin
			miscompares++;
			print_verdict;
		end
	end
	initial begin
		{rst_b, edit_valid, edit_commit, edit_discard, slow} = 5'h0;
		{query_valid, query_selector_ok, query_selector, range_lo_live} = 10'h0;
		edit_item = CQR_IT_ADJUSTMENT_QUERY;
		query_keyword = CQR_KW_ADJUSTMENT_QUERY;
		edit_index = 2'h0;
		edit_data = 32'h0;
		inst_avail = 3'h3;
		repeat (16) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		s_staged;
		s_codes;
		s_range;
		s_scale;
		s_bw;
		s_reset;
		s_err;
		print_verdict;
	end
endmodule : tb_top
